// ===== pkg/udi_cfg.svh
`ifndef UDI_CFG_SVH
`define UDI_CFG_SVH
// ****************************************
// Register map
// ****************************************
`define UDI_ADDR_REASON     12'h250
`define UDI_ADDR_ENABLE     12'h254
`define UDI_ADDR_EPSEL      12'h258
`define UDI_ADDR_DEVINT     12'h218
`define UDI_ADDR_CMD        12'h230
// ****************************************
// Fields and reset values
// ****************************************
`define UDI_BIT_STOP        12
`define UDI_BIT_EOT         10
`define UDI_BIT_DONE        8
`define UDI_SRC_MASK        16'h1500
`define UDI_EPSEL_MASK      8'h0f
`define UDI_DEVINT_DMA_BIT  6
`define UDI_CMD_STOP        8'h0f
`define UDI_RST_REASON      16'h0000
`define UDI_RST_ENABLE      16'h0000
`define UDI_RST_EPSEL       8'h00
`endif

// ===== pkg/udi_pkg.sv
package udi_pkg;
    typedef struct packed {
        logic stop;
        logic eot;
        logic done;
    } udi_evt_t;
    typedef struct packed {
        logic [2:0] ep;
        logic       dir;
    } udi_ep_t;
endpackage : udi_pkg

// ===== src/udi_evt_decode.sv
`timescale 1ns/1ps
`include "udi_cfg.svh"
// ****************************************
// Completion event decoder
// ****************************************
module udi_evt_decode
    import udi_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       cmd_stop,
    input  wire logic       xfer_end,
    input  wire logic       short_pkt,
    input  wire logic       cnt_zero,
    output udi_evt_t        evt_r,
    output logic            cmd_done_r
);
    udi_evt_t evt_nxt;
    logic     done_nxt;

    always_comb
    begin
        evt_nxt.stop = cmd_stop;
        evt_nxt.eot  = xfer_end & short_pkt;
        evt_nxt.done = xfer_end & cnt_zero;
        done_nxt     = cmd_stop | xfer_end;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            evt_r      <= '0;
            cmd_done_r <= 1'b0;
        end
        else if (ce)
        begin
            evt_r      <= evt_nxt;
            cmd_done_r <= done_nxt;
        end
    end

    eot_only_a: assert property (@(posedge sys_clk) disable iff (rst)
        ce && xfer_end && short_pkt && !cnt_zero |=> evt_r.eot && !evt_r.done)
        else $error("short packet did not flag eot only");
    both_a: assert property (@(posedge sys_clk) disable iff (rst)
        ce && xfer_end && short_pkt && cnt_zero |=> evt_r.eot && evt_r.done)
        else $error("short packet at zero did not flag both");
    done_only_a: assert property (@(posedge sys_clk) disable iff (rst)
        ce && xfer_end && !short_pkt && cnt_zero |=> !evt_r.eot && evt_r.done)
        else $error("clean end did not flag done only");
endmodule : udi_evt_decode

// ===== src/udi_irq_mask.sv
`timescale 1ns/1ps
// ****************************************
// Masked interrupt reduction
// ****************************************
module udi_irq_mask
#(
    parameter int W = 16
)
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] reason,
    input  wire logic [W-1:0] enable,
    output logic              pend_r
);
    logic pend_nxt;

    always_comb
    begin
        pend_nxt = |(reason & enable);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pend_r <= 1'b0;
        else if (ce)
            pend_r <= pend_nxt;
    end
endmodule : udi_irq_mask

// ===== src/udi_dma_irq.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "udi_cfg.svh"
module udi_dma_irq
    import udi_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        bus_rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        xfer_end,
    input  wire logic        short_pkt,
    input  wire logic        cnt_zero,
    output udi_ep_t          dma_ep_r,
    output logic             irq_r
);
    // ****************************************
    // Bus decode
    // ****************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    logic        acc;
    logic        wr;
    logic        mapped;
    logic        cmd_stop;
    logic        srst;
    udi_evt_t    evt_r;
    logic        cmd_done_r;
    logic        pend;

    assign srst = rst | bus_rst;
    assign acc  = psel & penable & ~pready;
    assign wr   = acc & pwrite;
    assign mapped = hit(paddr, `UDI_ADDR_REASON) | hit(paddr, `UDI_ADDR_ENABLE)
                  | hit(paddr, `UDI_ADDR_EPSEL) | hit(paddr, `UDI_ADDR_DEVINT)
                  | hit(paddr, `UDI_ADDR_CMD);
    assign cmd_stop = wr & hit(paddr, `UDI_ADDR_CMD)
                    & (pwdata[7:0] == `UDI_CMD_STOP);

    udi_evt_decode u_dec (
        .sys_clk    (sys_clk),
        .rst        (srst),
        .ce         (ce),
        .cmd_stop   (cmd_stop),
        .xfer_end   (xfer_end),
        .short_pkt  (short_pkt),
        .cnt_zero   (cnt_zero),
        .evt_r      (evt_r),
        .cmd_done_r (cmd_done_r)
    );

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] reason_r;
    logic [15:0] reason_nxt;
    logic [15:0] enable_r;
    logic [15:0] enable_nxt;
    logic [7:0]  epsel_r;
    logic [7:0]  epsel_nxt;
    logic        sum_r;
    logic        sum_nxt;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic        sum_set;

    udi_irq_mask #(.W(16)) u_mask (
        .sys_clk (sys_clk),
        .rst     (srst),
        .ce      (ce),
        .reason  (reason_r),
        .enable  (enable_r),
        .pend_r  (pend)
    );

    always_comb
    begin
        set_v = 16'h0000;
        set_v[`UDI_BIT_STOP] = evt_r.stop;
        set_v[`UDI_BIT_EOT]  = evt_r.eot;
        set_v[`UDI_BIT_DONE] = evt_r.done;
        clr_v = (wr && hit(paddr, `UDI_ADDR_REASON))
              ? (pwdata[15:0] & `UDI_SRC_MASK) : 16'h0000;
        reason_nxt = reason_r & ~clr_v;
        // Refresh on completion; a new event beats a same-cycle clear
        if (cmd_done_r)
            reason_nxt = (reason_nxt & ~(`UDI_SRC_MASK & ~set_v)) | set_v;
        enable_nxt = enable_r;
        if (wr && hit(paddr, `UDI_ADDR_ENABLE))
            enable_nxt = pwdata[15:0] & `UDI_SRC_MASK;
        epsel_nxt = epsel_r;
        if (wr && hit(paddr, `UDI_ADDR_EPSEL))
            epsel_nxt = pwdata[7:0] & `UDI_EPSEL_MASK;
        // Summary needs both the source clear and its own clear
        sum_set = pend;
        sum_nxt = sum_r;
        if (wr && hit(paddr, `UDI_ADDR_DEVINT) && pwdata[`UDI_DEVINT_DMA_BIT])
            sum_nxt = 1'b0;
        if (sum_set)
            sum_nxt = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            reason_r <= `UDI_RST_REASON;
            enable_r <= `UDI_RST_ENABLE;
            epsel_r  <= `UDI_RST_EPSEL;
            sum_r    <= 1'b0;
        end
        else if (ce)
        begin
            reason_r <= reason_nxt;
            enable_r <= enable_nxt;
            epsel_r  <= epsel_nxt;
            sum_r    <= sum_nxt;
        end
    end

    // ****************************************
    // Bus answer and outputs
    // ****************************************
    logic [31:0] rd_nxt;
    logic        rdy_nxt;
    logic        err_nxt;
    udi_ep_t     ep_nxt;
    logic        irq_nxt;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (hit(paddr, `UDI_ADDR_REASON))
            rd_nxt = {16'h0000, reason_r};
        else if (hit(paddr, `UDI_ADDR_ENABLE))
            rd_nxt = {16'h0000, enable_r};
        else if (hit(paddr, `UDI_ADDR_EPSEL))
            rd_nxt = {24'h000000, epsel_r};
        else if (hit(paddr, `UDI_ADDR_DEVINT))
            rd_nxt = {25'h0000000, sum_r, 6'h00};
        rdy_nxt = acc;
        err_nxt = acc & ~mapped;
        ep_nxt.ep  = epsel_r[3:1];
        ep_nxt.dir = epsel_r[0];
        irq_nxt = sum_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            dma_ep_r <= '0;
            irq_r    <= 1'b0;
        end
        else if (ce)
        begin
            prdata   <= (acc && !pwrite) ? rd_nxt : 32'h0000_0000;
            pready   <= rdy_nxt;
            pslverr  <= err_nxt;
            dma_ep_r <= ep_nxt;
            irq_r    <= irq_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    w1c_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && wr && hit(paddr, `UDI_ADDR_REASON) && pwdata[`UDI_BIT_DONE] && !cmd_done_r
        |=> !reason_r[`UDI_BIT_DONE])
        else $error("reason bit not cleared by one");
    w1c_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && wr && hit(paddr, `UDI_ADDR_REASON) && !pwdata[`UDI_BIT_STOP] && !cmd_done_r
        && reason_r[`UDI_BIT_STOP] |=> reason_r[`UDI_BIT_STOP])
        else $error("reason bit lost on zero write");
    stop_set_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && cmd_stop ##1 ce |=> reason_r[`UDI_BIT_STOP])
        else $error("stop command did not set bit 12");
    refresh_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && cmd_done_r |=> reason_r[`UDI_BIT_DONE] == $past(evt_r.done))
        else $error("reason not refreshed on completion");
    eot_set_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && xfer_end && short_pkt ##1 ce |=> reason_r[`UDI_BIT_EOT])
        else $error("eot not set");
    done_set_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && xfer_end && cnt_zero ##1 ce |=> reason_r[`UDI_BIT_DONE])
        else $error("done not set");
    mask_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && ((reason_r & enable_r) == 16'h0000) ##1 ce && !sum_r |=> !sum_r)
        else $error("masked source raised irq");
    irq_pend_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce && |(reason_r & enable_r) ##1 ce ##1 ce |=> irq_r)
        else $error("enabled source gave no irq");
    ep_map_a: assert property (@(posedge sys_clk) disable iff (srst)
        ce |=> dma_ep_r.dir == $past(epsel_r[0]))
        else $error("direction not from bit 0");
    en_reset_a: assert property (@(posedge sys_clk)
        bus_rst |=> enable_r == 16'h0000)
        else $error("enable not cleared by reset");
endmodule : udi_dma_irq

// ===== tb/udi_evt_src.sv
`timescale 1ns/1ps
// ****************************************
// DMA engine completion source
// ****************************************
module udi_evt_src
(
    input  wire logic sys_clk,
    input  wire logic go,
    input  wire logic sp,
    input  wire logic cz,
    output logic      xfer_end,
    output logic      short_pkt,
    output logic      cnt_zero
);
    initial
    begin
        xfer_end  = 1'h0;
        short_pkt = 1'h0;
        cnt_zero  = 1'h0;
    end
    // Levels toggle outside the pulse so stale values are never trusted
    always @(posedge sys_clk)
    begin
        xfer_end  <= go;
        short_pkt <= go ? sp : ~short_pkt;
        cnt_zero  <= go ? cz : ~cnt_zero;
    end
endmodule : udi_evt_src

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "udi_cfg.svh"
module tb_top
    import udi_pkg::*;
;
    logic        sys_clk = 1'h0;
    logic        rst     = 1'h1;
    logic        bus_rst = 1'h0;
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic        go      = 1'h0;
    logic        sp      = 1'h0;
    logic        cz      = 1'h0;
    logic        ce      = 1'h1;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, irq, xfer_end, short_pkt, cnt_zero;
    udi_ep_t     dma_ep;
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cyc       = 0;

    always #10 sys_clk = ~sys_clk;

    udi_evt_src src (.sys_clk(sys_clk), .go(go), .sp(sp), .cz(cz), .xfer_end(xfer_end),
                     .short_pkt(short_pkt), .cnt_zero(cnt_zero));
    udi_dma_irq dut (.sys_clk(sys_clk), .rst(rst), .bus_rst(bus_rst), .ce(ce),
                     .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                     .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                     .xfer_end(xfer_end), .short_pkt(short_pkt), .cnt_zero(cnt_zero),
                     .dma_ep_r(dma_ep), .irq_r(irq));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Entered just after a rising edge; the idle edge at the end avoids double drives
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask : rdc

    // Reason bits after three edges, summary after two more
    task automatic evt(input logic s, input logic c);
        go <= 1'h1;
        sp <= s;
        cz <= c;
        @(posedge sys_clk);
        go <= 1'h0;
        repeat (8) @(posedge sys_clk);
    endtask : evt

    function automatic logic [31:0] bitv(input int b);
        return 32'h1 << b;
    endfunction : bitv

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdc(`UDI_ADDR_REASON, 32'(`UDI_RST_REASON));
        rdc(`UDI_ADDR_ENABLE, 32'(`UDI_RST_ENABLE));
        rdc(`UDI_ADDR_EPSEL, 32'(`UDI_RST_EPSEL));
        wr(`UDI_ADDR_ENABLE, 32'(`UDI_SRC_MASK));
        bus_rst <= 1'h1;
        @(posedge sys_clk);
        bus_rst <= 1'h0;
        @(posedge sys_clk);
        rdc(`UDI_ADDR_ENABLE, 32'h0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_events();
        logic [1:0] cs [3];
        cs = '{2'h2, 2'h3, 2'h1};
        // No clear between events: each completion refreshes every bit
        foreach (cs[i])
        begin
            evt(cs[i][1], cs[i][0]);
            rdc(`UDI_ADDR_REASON, (cs[i][1] ? bitv(`UDI_BIT_EOT) : 32'h0) |
                (cs[i][0] ? bitv(`UDI_BIT_DONE) : 32'h0));
        end
        $display("t_events done");
    endtask : t_events

    task automatic t_stop();
        evt(1'h1, 1'h1);
        wr(`UDI_ADDR_REASON, bitv(`UDI_BIT_DONE));
        rdc(`UDI_ADDR_REASON, bitv(`UDI_BIT_EOT));
        wr(`UDI_ADDR_REASON, 32'h0);
        rdc(`UDI_ADDR_REASON, bitv(`UDI_BIT_EOT));
        wr(`UDI_ADDR_REASON, 32'(`UDI_SRC_MASK));
        rdc(`UDI_ADDR_REASON, 32'h0);
        wr(`UDI_ADDR_CMD, 32'(`UDI_CMD_STOP));
        repeat (8) @(posedge sys_clk);
        rdc(`UDI_ADDR_REASON, bitv(`UDI_BIT_STOP));
        wr(`UDI_ADDR_REASON, bitv(`UDI_BIT_EOT));
        rdc(`UDI_ADDR_REASON, bitv(`UDI_BIT_STOP));
        wr(`UDI_ADDR_REASON, 32'(`UDI_SRC_MASK));
        $display("t_stop done");
    endtask : t_stop

    task automatic t_irq();
        logic [31:0] why;
        wr(`UDI_ADDR_ENABLE, bitv(`UDI_BIT_EOT));
        evt(1'h0, 1'h1);
        check(32'(irq), 32'h0);
        evt(1'h1, 1'h0);
        check(32'(irq), 32'h1);
        rdc(`UDI_ADDR_DEVINT, bitv(`UDI_DEVINT_DMA_BIT));
        apb(1'h0, `UDI_ADDR_REASON, 32'h0);
        why = rd;
        apb(1'h0, `UDI_ADDR_ENABLE, 32'h0);
        check(why & rd, bitv(`UDI_BIT_EOT));
        // Summary cleared first stays set while the source is still pending
        wr(`UDI_ADDR_DEVINT, bitv(`UDI_DEVINT_DMA_BIT));
        repeat (4) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        wr(`UDI_ADDR_REASON, bitv(`UDI_BIT_EOT));
        repeat (4) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        wr(`UDI_ADDR_DEVINT, bitv(`UDI_DEVINT_DMA_BIT));
        repeat (4) @(posedge sys_clk);
        check(32'(irq), 32'h0);
        $display("t_irq done");
    endtask : t_irq

    task automatic t_ep();
        for (int i = 0; i < 16; i++)
        begin
            wr(`UDI_ADDR_EPSEL, 32'(i));
            check(32'(dma_ep), 32'(i));
            rdc(`UDI_ADDR_EPSEL, 32'(i));
        end
        // Park on an endpoint other than the last one the loop selected
        wr(`UDI_ADDR_EPSEL, 32'h0e);
        apb(1'h1, 12'h2fc, 32'h1500);
        check(32'(er), 32'h1);
        rdc(`UDI_ADDR_REASON, 32'h0);
        apb(1'h0, 12'h2fc, 32'h0);
        check(rd, 32'h0);
        check(32'(er), 32'h1);
        $display("t_ep done");
    endtask : t_ep

    task automatic t_freeze();
        // Frozen core misses the completion pulse entirely
        ce <= 1'h0;
        evt(1'h1, 1'h1);
        ce <= 1'h1;
        @(posedge sys_clk);
        rdc(`UDI_ADDR_REASON, 32'h0);
        check(32'(irq), 32'h0);
        $display("t_freeze done");
    endtask : t_freeze

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            results();
        end
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        t_reset();
        t_events();
        t_stop();
        t_irq();
        t_ep();
        t_freeze();
        results();
    end
endmodule : tb_top
